// File: pkg/msg_pkg.sv
// constants, register map and types shared by the message text display controller
package msg_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int NUM_MSG = 50;
    localparam int IDX_W = 6;
    localparam int PRIO_W = 7;
    localparam int LINES = 4;
    localparam logic [4:0] LINE_CHARS = 5'h18;
    localparam logic [4:0] HALF_CHARS = 5'h0c;
    localparam logic [3:0] HALF_TICKS = 4'ha;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 250;
    localparam int SCROLL_INTERVAL_US = 100000;
    localparam int SCROLL_CYCLES = SCROLL_INTERVAL_US * CLK_MHZ;
    localparam int ANALOG_PERIOD_US = 100000;
    localparam int ANALOG_CYCLES = ANALOG_PERIOD_US * CLK_MHZ;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] SCROLL_OFS = 12'h004;
    localparam logic [11:0] ANALOG_OFS = 12'h008;
    localparam logic [11:0] STATUS_OFS = 12'h00c;
    localparam logic [11:0] TIME_OFS = 12'h010;
    localparam logic [11:0] DATE_OFS = 12'h014;
    localparam logic [11:0] STAMP_T_OFS = 12'h018;
    localparam logic [11:0] STAMP_D_OFS = 12'h01c;
    localparam logic [11:0] AVAL_OFS = 12'h020;
    localparam logic [11:0] CFG_BASE = 12'h100;
    localparam logic [11:0] CFG_END = 12'h1c8;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_CSEL_BIT = 1;
    localparam int CTRL_CUSE_BIT = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam int DEST_MAIN_BIT = 0;
    localparam int DEST_REMOTE_BIT = 1;

    typedef enum logic {
        SCROLL_CHAR = 1'b0,
        SCROLL_HALF = 1'b1
    } scroll_e;

    typedef struct packed {
        logic [3:0] line_scroll;
        scroll_e mode;
        logic charset;
        logic [1:0] dest;
        logic ack_en;
        logic [6:0] prio;
    } msg_cfg_s;

    localparam logic [15:0] CFG_RST = 16'h0100;

endpackage

// File: logic/msg_display.sv
// message text display controller: activation, arbitration, scrolling and apb registers
`timescale 1ns/10ps
`default_nettype none
module msg_display #(
    parameter int SCROLL_DEF = msg_pkg::SCROLL_CYCLES,
    parameter int ANALOG_DEF = msg_pkg::ANALOG_CYCLES
) (
    input wire logic mclk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [11:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic [msg_pkg::NUM_MSG-1:0] trig, // per message trigger pins
    input wire logic key_ok, // confirm key
    input wire logic key_up, // up key
    input wire logic key_down, // down key
    input wire logic [31:0] tod, // time of day source
    input wire logic [31:0] day, // date source
    input wire logic [15:0] analog_in, // analog input value
    output logic [msg_pkg::NUM_MSG-1:0] shown_flag, // message set state
    output logic shown_valid, // a message is on view
    output logic [msg_pkg::IDX_W-1:0] shown_idx, // message on view
    output logic main_on, // view goes to main screen
    output logic remote_on, // view goes to remote screen
    output logic [msg_pkg::LINES-1:0] line_scroll, // lines that scroll
    output logic [4:0] col_offset, // left rotation of scrolling lines
    output logic [31:0] live_time, // refreshed time of day
    output logic [31:0] live_date, // refreshed date
    output logic [31:0] stamp_time, // time stamp of shown message
    output logic [31:0] stamp_date, // date stamp of shown message
    output logic [15:0] analog_value // refreshed analog field
);
    import msg_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    // lowest index wins a priority tie
    function automatic logic [IDX_W:0] pick_best(input logic [NUM_MSG-1:0] mask,
                                                  input logic [NUM_MSG-1:0][PRIO_W-1:0] pr);
        logic found;
        logic [IDX_W-1:0] idx;
        logic [PRIO_W-1:0] bp;
        found = 1'b0;
        idx = '0;
        bp = '0;
        for (int i = 0; i < NUM_MSG; i++) begin
            if (mask[i] && (!found || pr[i] > bp)) begin
                found = 1'b1;
                idx = IDX_W'(i);
                bp = pr[i];
            end
        end
        return {found, idx};
    endfunction

    // next active message after cur in the given direction, wrapping
    function automatic logic [IDX_W:0] pick_step(input logic [NUM_MSG-1:0] mask,
                                                  input logic [IDX_W-1:0] cur, input logic up);
        logic found;
        logic [IDX_W-1:0] idx;
        int j;
        found = 1'b0;
        idx = '0;
        j = 0;
        for (int k = 1; k < NUM_MSG; k++) begin
            j = up ? (int'(cur) + k) % NUM_MSG : (int'(cur) + NUM_MSG - k) % NUM_MSG;
            if (!found && mask[j]) begin
                found = 1'b1;
                idx = IDX_W'(j);
            end
        end
        return {found, idx};
    endfunction

    // ****************************************
    // storage
    // ****************************************
    logic [2:0] ctrl;
    logic [31:0] scroll_int;
    logic [31:0] analog_int;
    msg_cfg_s cfg [NUM_MSG];
    logic [31:0] stamp_t [NUM_MSG];
    logic [31:0] stamp_d [NUM_MSG];
    logic [NUM_MSG-1:0] trig_s1;
    logic [NUM_MSG-1:0] trig_s2;
    logic [NUM_MSG-1:0] trig_d;
    logic [2:0] key_s1;
    logic [2:0] key_s2;
    logic [2:0] key_d;
    logic [31:0] tick_cnt;
    logic [3:0] half_cnt;
    logic [31:0] ana_cnt;

    // ****************************************
    // input edges
    // ****************************************
    wire [NUM_MSG-1:0] trig_rise = trig_s2 & ~trig_d;
    wire [NUM_MSG-1:0] trig_fall = ~trig_s2 & trig_d;
    wire key_ok_p = key_s2[0] & ~key_d[0];
    wire key_up_p = key_s2[1] & ~key_d[1];
    wire key_dn_p = key_s2[2] & ~key_d[2];
    wire run_mode = ctrl[CTRL_RUN_BIT];
    wire [NUM_MSG-1:0] new_set = run_mode ? trig_rise : '0;

    // ****************************************
    // per message decode
    // ****************************************
    wire [NUM_MSG-1:0][PRIO_W-1:0] prio_vec;
    wire [NUM_MSG-1:0] cs_ok;
    wire [NUM_MSG-1:0] ack_clear;
    wire [NUM_MSG-1:0] off_clear;
    genvar g;
    generate
        for (g = 0; g < NUM_MSG; g++) begin : g_msg
            assign prio_vec[g] = cfg[g].prio;
            // only the selected glyph table may show while filtering is on
            assign cs_ok[g] = !ctrl[CTRL_CUSE_BIT] || (cfg[g].charset == ctrl[CTRL_CSEL_BIT]);
            // confirm acts only on the message in view whose trigger is already low
            assign ack_clear[g] = key_ok_p && shown_valid && (shown_idx == IDX_W'(g)) && cfg[g].ack_en
                                  && !trig_s2[g];
            assign off_clear[g] = trig_fall[g] && !cfg[g].ack_en;
        end
    endgenerate

    // a rise in the same cycle as a clear keeps the message set
    wire [NUM_MSG-1:0] next_active = new_set | (shown_flag & ~(ack_clear | off_clear));
    wire [NUM_MSG-1:0] eligible = next_active & cs_ok;

    // ****************************************
    // arbitration
    // ****************************************
    wire [IDX_W:0] best_all = pick_best(eligible, prio_vec);
    wire [IDX_W:0] best_new = pick_best(new_set & cs_ok, prio_vec);
    wire [IDX_W:0] step_up = pick_step(eligible, shown_idx, 1'b1);
    wire [IDX_W:0] step_dn = pick_step(eligible, shown_idx, 1'b0);
    wire cur_ok = shown_valid && eligible[shown_idx];
    // strict compare: an equal newcomer leaves the view alone
    wire new_wins = best_new[IDX_W] && (prio_vec[best_new[IDX_W-1:0]] > prio_vec[shown_idx]);
    wire [IDX_W:0] next_sel = !cur_ok ? best_all :
                              (key_up_p && step_up[IDX_W]) ? step_up :
                              (key_dn_p && step_dn[IDX_W]) ? step_dn :
                              new_wins ? best_new :
                              {1'b1, shown_idx};
    wire next_valid = next_sel[IDX_W];
    wire [IDX_W-1:0] next_idx = next_sel[IDX_W-1:0];
    wire view_change = (next_valid != shown_valid) || (next_idx != shown_idx);
    msg_cfg_s next_cfg;
    assign next_cfg = cfg[next_idx];

    // ****************************************
    // scroll timing
    // ****************************************
    // the interval restarts with every new view so the first step lands one interval later
    wire tick = (tick_cnt >= scroll_int - 32'h1);
    wire half_flip = tick && (half_cnt == HALF_TICKS - 4'h1);
    wire [4:0] char_next = (col_offset == LINE_CHARS - 5'h1) ? 5'h0 : col_offset + 5'h1;
    wire [4:0] half_next = (col_offset == 5'h0) ? HALF_CHARS : 5'h0;
    wire ana_tick = (ana_cnt >= analog_int - 32'h1);

    // ****************************************
    // apb decode
    // ****************************************
    wire setup = psel && !penable;
    wire wr_en = psel && penable && pready && pwrite;
    wire cfg_hit = (paddr >= CFG_BASE) && (paddr < CFG_END) && (paddr[1:0] == 2'h0);
    wire [11:0] cfg_rel = paddr - CFG_BASE;
    wire [IDX_W-1:0] cfg_sel = cfg_rel[IDX_W+1:2];
    wire mapped = cfg_hit || (paddr == CTRL_OFS) || (paddr == SCROLL_OFS) || (paddr == ANALOG_OFS)
                  || (paddr == STATUS_OFS) || (paddr == TIME_OFS) || (paddr == DATE_OFS)
                  || (paddr == STAMP_T_OFS) || (paddr == STAMP_D_OFS) || (paddr == AVAL_OFS);
    wire [31:0] status_word = {16'h0, col_offset, remote_on, main_on, shown_valid, 2'h0, shown_idx};
    wire [31:0] rd_data = cfg_hit ? {16'h0, cfg[cfg_sel]} :
                          (paddr == CTRL_OFS) ? {29'h0, ctrl} :
                          (paddr == SCROLL_OFS) ? scroll_int :
                          (paddr == ANALOG_OFS) ? analog_int :
                          (paddr == STATUS_OFS) ? status_word :
                          (paddr == TIME_OFS) ? live_time :
                          (paddr == DATE_OFS) ? live_date :
                          (paddr == STAMP_T_OFS) ? stamp_time :
                          (paddr == STAMP_D_OFS) ? stamp_date :
                          (paddr == AVAL_OFS) ? {16'h0, analog_value} : 32'h0;

    // ****************************************
    // synchronisers
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trig_s1 <= '0;
            trig_s2 <= '0;
            trig_d <= '0;
            key_s1 <= 3'h0;
            key_s2 <= 3'h0;
            key_d <= 3'h0;
        end else begin
            trig_s1 <= trig;
            trig_s2 <= trig_s1;
            trig_d <= trig_s2;
            key_s1 <= {key_down, key_up, key_ok};
            key_s2 <= key_s1;
            key_d <= key_s2;
        end
    end

    // ****************************************
    // apb slave
    // ****************************************
    // one wait-free access phase: answer is ready in the cycle after setup
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= setup ? rd_data : 32'h0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RST;
            scroll_int <= 32'(SCROLL_DEF);
            analog_int <= 32'(ANALOG_DEF);
        end else if (wr_en) begin
            if (paddr == CTRL_OFS) begin
                ctrl <= pwdata[2:0];
            end
            if (paddr == SCROLL_OFS) begin
                scroll_int <= pwdata;
            end
            if (paddr == ANALOG_OFS) begin
                analog_int <= pwdata;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_MSG; i++) begin
                cfg[i] <= msg_cfg_s'(CFG_RST);
            end
        end else if (wr_en && cfg_hit) begin
            cfg[cfg_sel] <= msg_cfg_s'(pwdata[15:0]);
        end
    end

    // ****************************************
    // message state and stamps
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shown_flag <= '0;
        end else begin
            shown_flag <= next_active;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_MSG; i++) begin
                stamp_t[i] <= 32'h0;
                stamp_d[i] <= 32'h0;
            end
        end else begin
            for (int i = 0; i < NUM_MSG; i++) begin
                if (new_set[i]) begin
                    stamp_t[i] <= tod;
                    stamp_d[i] <= day;
                end
            end
        end
    end

    // ****************************************
    // view
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shown_valid <= 1'b0;
            shown_idx <= '0;
            main_on <= 1'b0;
            remote_on <= 1'b0;
            line_scroll <= '0;
        end else begin
            shown_valid <= next_valid;
            shown_idx <= next_idx;
            main_on <= next_valid && next_cfg.dest[DEST_MAIN_BIT];
            remote_on <= next_valid && next_cfg.dest[DEST_REMOTE_BIT];
            line_scroll <= next_valid ? next_cfg.line_scroll : '0;
        end
    end

    // stamps follow the view one cycle late, after the capture has landed
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            live_time <= 32'h0;
            live_date <= 32'h0;
            stamp_time <= 32'h0;
            stamp_date <= 32'h0;
        end else begin
            live_time <= tod;
            live_date <= day;
            stamp_time <= stamp_t[shown_idx];
            stamp_date <= stamp_d[shown_idx];
        end
    end

    // ****************************************
    // scrolling
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 32'h0;
            half_cnt <= 4'h0;
            col_offset <= 5'h0;
        end else if (view_change || !shown_valid) begin
            tick_cnt <= 32'h0;
            half_cnt <= 4'h0;
            col_offset <= 5'h0;
        end else if (tick) begin
            tick_cnt <= 32'h0;
            if (cfg[shown_idx].mode == SCROLL_HALF) begin
                half_cnt <= half_flip ? 4'h0 : half_cnt + 4'h1;
                col_offset <= half_flip ? half_next : col_offset;
            end else begin
                col_offset <= char_next;
            end
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end

    // ****************************************
    // analog field
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ana_cnt <= 32'h0;
            analog_value <= 16'h0;
        end else if (ana_tick) begin
            ana_cnt <= 32'h0;
            analog_value <= analog_in;
        end else begin
            ana_cnt <= ana_cnt + 32'h1;
        end
    end

endmodule
`default_nettype wire

// File: testbench/msg_display_sva.sv
// port level assertion checker for the message display controller
`timescale 1ns/10ps
`default_nettype none
module msg_display_sva
    import msg_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic [11:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic [NUM_MSG-1:0] trig, // triggers
    input wire logic [31:0] tod, // time source
    input wire logic [NUM_MSG-1:0] shown_flag, // set state
    input wire logic shown_valid, // view valid
    input wire logic [IDX_W-1:0] shown_idx, // view index
    input wire logic main_on, // main screen
    input wire logic remote_on, // remote screen
    input wire logic [LINES-1:0] line_scroll, // scrolling lines
    input wire logic [4:0] col_offset, // rotation
    input wire logic [31:0] live_time // live time
);
    logic run_q;

    // ****************************************
    // run mode shadow, so trigger checks know when rises count
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == CTRL_OFS) begin
            run_q <= pwdata[CTRL_RUN_BIT];
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("pready held too long");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_PRDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside access");
    AST_IDX_RANGE: assert property (shown_valid |-> shown_idx < NUM_MSG)
        else $error("view index out of range");
    AST_VIEW_IS_SET: assert property (shown_valid |-> shown_flag[shown_idx])
        else $error("viewed message not set");
    AST_IDLE_DARK: assert property (!shown_valid |-> !(main_on || remote_on) && line_scroll == 4'h0)
        else $error("screen active without a view");
    AST_COL_RANGE: assert property (col_offset < 5'h18)
        else $error("rotation out of range");
    AST_COL_STEP: assert property (shown_valid && $past(shown_valid) && $stable(shown_idx) && $changed(col_offset)
        |-> col_offset == 5'h0 || col_offset == 5'h0c || col_offset == $past(col_offset) + 5'h1)
        else $error("rotation skipped a step");
    AST_LIVE_TIME: assert property ($past(rst_n, 2) |-> live_time == $past(tod))
        else $error("live time not following source");
    AST_TRIG_SETS: assert property ($rose(trig[0]) && run_q ##1 trig[0] [*5] |-> ##[0:4] shown_flag[0])
        else $error("trigger rise did not set message");

    CV_BOTH_SCREENS: cover property (shown_valid && main_on && remote_on);
    CV_UNMAPPED: cover property (pslverr);
    CV_SECOND_SET: cover property ($rose(shown_flag[1]));
endmodule
bind msg_display msg_display_sva msg_display_sva_i (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig(trig), .tod(tod), .shown_flag(shown_flag), .shown_valid(shown_valid), .shown_idx(shown_idx),
    .main_on(main_on), .remote_on(remote_on), .line_scroll(line_scroll), .col_offset(col_offset),
    .live_time(live_time));
`default_nettype wire

// File: testbench/keypad_user.sv
// keypad user model pressing confirm, up and down keys
`timescale 1ns/10ps
`default_nettype none
module keypad_user (
    input wire logic mclk, // clock
    output logic key_ok, // confirm key
    output logic key_up, // up key
    output logic key_down // down key
);
    initial begin
        key_ok = 1'b0;
        key_up = 1'b0;
        key_down = 1'b0;
    end

    // k: 0 confirm, 1 up, 2 down; long low phase so edge detect sees each press
    task automatic press(input int k);
        @(posedge mclk);
        key_ok <= (k == 0);
        key_up <= (k == 1);
        key_down <= (k == 2);
        repeat (4) @(posedge mclk);
        key_ok <= 1'b0;
        key_up <= 1'b0;
        key_down <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// File: testbench/msg_display_tb.sv
// self-checking testbench for the message display controller
`timescale 1ns/10ps
`default_nettype none
module msg_display_tb;
    import msg_pkg::*;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, key_ok, key_up, key_down;
    logic shown_valid, main_on, remote_on, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, tod, day, live_time, live_date, stamp_time, stamp_date, rdata;
    logic [NUM_MSG-1:0] trig, shown_flag;
    logic [IDX_W-1:0] shown_idx;
    logic [LINES-1:0] line_scroll;
    logic [4:0] col_offset;
    logic [15:0] analog_in, analog_value;
    int fail_count, n_compared, c;

    msg_display #(.SCROLL_DEF(8), .ANALOG_DEF(8)) msg_display_i (.mclk(mclk), .rst_n(rst_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig(trig), .key_ok(key_ok), .key_up(key_up), .key_down(key_down), .tod(tod),
        .day(day), .analog_in(analog_in), .shown_flag(shown_flag), .shown_valid(shown_valid),
        .shown_idx(shown_idx), .main_on(main_on), .remote_on(remote_on), .line_scroll(line_scroll),
        .col_offset(col_offset), .live_time(live_time), .live_date(live_date), .stamp_time(stamp_time),
        .stamp_date(stamp_date), .analog_value(analog_value));
    keypad_user keypad_user_i (.mclk(mclk), .key_ok(key_ok), .key_up(key_up), .key_down(key_down));

    // ****************************************
    // helpers
    // ****************************************
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) fail_count++;
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic set_trig(input int i, input logic v);
        @(posedge mclk);
        trig[i] <= v;
        repeat (8) @(posedge mclk);
    endtask

    // cycles until the rotation next changes
    task automatic gap(output int n);
        logic [4:0] s;
        s = col_offset;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (col_offset === s && n < 400);
    endtask

    task automatic view(input string nm, input logic [5:0] idx, input logic m, input logic r);
        chk(nm, {24'h0, shown_valid, main_on, remote_on, shown_idx[4:0]}, {24'h0, 1'b1, m, r, idx[4:0]});
        chk({nm, " hi"}, {31'h0, shown_idx[5]}, {31'h0, idx[5]});
    endtask

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial begin
        repeat (6000) @(posedge mclk);
        fail_count++;
        end_of_test();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        trig = '0;
        tod = 32'h00001234;
        day = 32'h00000701;
        analog_in = 16'h0abc;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk("flags idle", {31'h0, |shown_flag}, 32'h0);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl reset", rdata, 32'h0);
        apb(1'b0, CFG_BASE, 32'h0);
        chk("cfg reset", rdata, 32'h00000100);
        apb(1'b0, CFG_END, 32'h0);
        chk("slot 50 refused", {31'h0, rerr}, 32'h1);
        apb(1'b1, CFG_BASE, 32'h00000105);
        apb(1'b1, CFG_BASE + 12'h004, 32'h00000389);
        apb(1'b1, CFG_BASE + 12'h008, 32'h00000209);
        apb(1'b1, CFG_BASE + 12'h010, 32'h0000017f);
        apb(1'b0, CFG_BASE + 12'h004, 32'h0);
        chk("cfg readback", rdata, 32'h00000389);
        set_trig(0, 1'b1);
        chk("stopped rise", {31'h0, shown_flag[0]}, 32'h0);
        set_trig(0, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h1);
        set_trig(0, 1'b1);
        chk("flag0", {31'h0, shown_flag[0]}, 32'h1);
        view("view0", 6'h0, 1'b1, 1'b0);
        chk("stamp time", stamp_time, 32'h00001234);
        chk("stamp date", stamp_date, 32'h00000701);
        tod <= tod + 32'h00004444;
        day <= day + 32'h00000100;
        repeat (4) @(posedge mclk);
        chk("live time", live_time, 32'h00005678);
        chk("live date", live_date, 32'h00000801);
        chk("stamp kept", stamp_time, 32'h00001234);
        chk("date kept", stamp_date, 32'h00000701);
        set_trig(1, 1'b1);
        view("higher takes", 6'h1, 1'b1, 1'b1);
        set_trig(2, 1'b1);
        view("equal waits", 6'h1, 1'b1, 1'b1);
        chk("flag2", {31'h0, shown_flag[2]}, 32'h1);
        keypad_user_i.press(0);
        view("ok while high", 6'h1, 1'b1, 1'b1);
        set_trig(1, 1'b0);
        chk("ack held", {31'h0, shown_flag[1]}, 32'h1);
        keypad_user_i.press(0);
        chk("ack cleared", {31'h0, shown_flag[1]}, 32'h0);
        view("next best", 6'h2, 1'b0, 1'b1);
        set_trig(2, 1'b0);
        chk("fall clears", {31'h0, shown_flag[2]}, 32'h0);
        view("back to 0", 6'h0, 1'b1, 1'b0);
        set_trig(3, 1'b1);
        view("lower waits", 6'h0, 1'b1, 1'b0);
        keypad_user_i.press(1);
        view("key up", 6'h3, 1'b1, 1'b0);
        keypad_user_i.press(2);
        view("key down", 6'h0, 1'b1, 1'b0);
        set_trig(4, 1'b1);
        view("top prio", 6'h4, 1'b1, 1'b0);
        apb(1'b1, CFG_BASE, 32'h00001105);
        @(posedge mclk);
        trig[4] <= 1'b0;
        c = 0;
        do begin
            @(posedge mclk);
            c++;
        end while (shown_idx !== 6'h0 && c < 20);
        chk("scroll lines", {28'h0, line_scroll}, 32'h1);
        gap(c);
        chk("first tick", c, 8);
        chk("one char", {27'h0, col_offset}, 32'h1);
        gap(c);
        chk("char tick", c, 8);
        apb(1'b1, CFG_BASE, 32'h00001905);
        gap(c);
        gap(c);
        chk("half tick", c, 80);
        chk("half col", {31'h0, col_offset === 5'h0 || col_offset === 5'h0c}, 32'h1);
        chk("analog", {16'h0, analog_value}, 32'h00000abc);
        analog_in <= 16'h0123;
        repeat (20) @(posedge mclk);
        chk("analog new", {16'h0, analog_value}, 32'h00000123);
        apb(1'b1, CTRL_OFS, 32'h7);
        repeat (8) @(posedge mclk);
        chk("filtered", {31'h0, shown_valid}, 32'h0);
        chk("still set", {31'h0, shown_flag[0]}, 32'h1);
        apb(1'b1, CTRL_OFS, 32'h5);
        repeat (8) @(posedge mclk);
        chk("unfiltered", {31'h0, shown_valid}, 32'h1);
        end_of_test();
    end
endmodule
`default_nettype wire
